/* design/wwdt_pkg.sv */
package wwdt_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 40;
	// oscillator tick: resistor sets it; modelled as a clock divider
	localparam int OSC_DIV        = 40;
	localparam int OSC_DIV_W      = 6;
	// base period in oscillator ticks (low range); divisible by 9 and 5
	localparam int BASE_TICKS     = 90;
	localparam int RANGE_MULT     = 5;
	localparam int INIT_MULT      = 8;
	localparam int RATIO_DIV      = 9;
	localparam int HOLD_DIV       = 5;
	localparam int TICK_W         = 16;
	localparam int DEGLITCH_US    = 180;
	localparam int DLY_FIX_US     = 248;
	localparam int DEGLITCH_CYC   = DEGLITCH_US * CLK_MHZ;
	localparam int DLY_FIX_CYC    = DLY_FIX_US * CLK_MHZ;
	localparam int DLY_W          = 24;
	localparam logic [DLY_W-1:0] DLY_ZERO = 24'h000000;

	// ----------------------------------------------------------------
	// grouped configuration pins
	// ----------------------------------------------------------------
	typedef struct packed {
		logic watchdogTypeSelect;
		logic periodRangeSelect;
		logic windowRatioSelect;
	} wwdt_cfg_s;

	typedef enum logic [1:0] {
		WD_IDLE,
		WD_OPEN,
		WD_CLOSED,
		WD_FAULT
	} wwdt_state_e;

endpackage

/* design/wwdt_sync.sv */
`timescale 1ns/1ps
module wwdt_sync
	import wwdt_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule

/* design/wwdt_top.sv */
`timescale 1ns/1ps
// How it works
// RL1: type select low runs windowed mode with closed then open portions.
// RL2: range select high makes the period five times longer.
// RL3: period and fault pulse are whole multiples of the oscillator tick.
// RL4: after initialization the first open window lasts eight periods.
// RL5: ratio select low splits period into equal closed and open halves.
// RL6: ratio select high makes open eight times the closed portion.
// RL7: closed plus open portions equal exactly one period.
// RL8: controller must service within the initialization window or faults.
// RL9: fault on service in closed portion or open portion ending unserviced.
// RL10: power-good rises only after the power-good delay fully elapses.
// RL11: power-good drops only after a deglitch interval; enable low, undervoltage or over-temperature drop it at once.
// RL12: without a delay capacitor a fixed default delay is used.
// RL13: enable low keeps regulator and dependent logic off.
// RL14: undervoltage dip forces shutdown and full power-up sequence again.
// RL15: over-temperature turns output off until below trip minus hysteresis.
// RL16: accepted service clears counter and starts new period, closed first in windowed mode.
// RL17: watchdog runs only with power-good high and enable_n low; else hi-Z.
// RL18: each fault pulls fault output low for one fifth of the period.
// RL19: type select high runs standard mode with no closed portion.
// RL20: service input is synchronized; each rising edge is one event.
// RL21: re-initialize on power-good rise, enable fall, and fault pulse end.
module wwdt_top
	import wwdt_pkg::*;
#(
	parameter int DLY_FIX_CYCLES  = DLY_FIX_CYC,
	parameter int DEGLITCH_CYCLES = DEGLITCH_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        deviceEnable,
	input  wire logic        underVoltage,
	input  wire logic        thermalShutdown,
	input  wire logic        outputInRegulation,
	input  wire logic        delayCapFitted,
	input  wire logic [23:0] delayCapCycles,
	input  wire logic        service_input,
	input  wire logic        watchdog_enable_n,
	input  wire wwdt_cfg_s   cfgPins,
	output logic             regulatorOn,
	output logic             power_good,
	output logic             fault_output_o,
	output logic             fault_output_oe_n,
	output logic             watchdogRunning
);
	// ----------------------------------------------------------------
	// synchronizers: every pin except delayCapFitted and delayCapCycles crosses two flops
	// ----------------------------------------------------------------
	logic [8:0] pinsSync;
	wwdt_sync #(.W(9)) uSync (
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  ({deviceEnable, underVoltage, thermalShutdown, outputInRegulation,
		            service_input, watchdog_enable_n, cfgPins}),
		.syncOut  (pinsSync)
	);
	logic enS, uvS, tsdS, regS, svcS, wdEnNS;
	wwdt_cfg_s cfgS;
	assign {enS, uvS, tsdS, regS, svcS, wdEnNS} = pinsSync[8:3];
	assign cfgS = pinsSync[2:0];

	function automatic logic [TICK_W-1:0] ticksOf(input int n);
		ticksOf = TICK_W'(n);
	endfunction

	// ----------------------------------------------------------------
	// regulator supervision
	// ----------------------------------------------------------------
	logic regAllowed;
	assign regAllowed = enS && !uvS && !tsdS; // RL13 RL14 RL15
	// thermal hysteresis lives in the comparator: tsd flag falls at trip minus hyst
	always_ff @(posedge core_clk) begin
		if (rst) regulatorOn <= 1'b0;
		else regulatorOn <= regAllowed; // RL15
	end

	// ----------------------------------------------------------------
	// power good delay and deglitch
	// ----------------------------------------------------------------
	logic [DLY_W-1:0] pgCnt_q;
	logic [DLY_W-1:0] pgDelay;
	assign pgDelay = delayCapFitted ? delayCapCycles : DLY_W'(DLY_FIX_CYCLES); // RL12

	always_ff @(posedge core_clk) begin
		if (rst || !regAllowed) begin // RL14
			pgCnt_q    <= DLY_ZERO;
			power_good <= 1'b0;
		end else if (!power_good) begin
			if (!regS) pgCnt_q <= DLY_ZERO;
			else if (pgCnt_q >= pgDelay) power_good <= 1'b1; // RL10
			else pgCnt_q <= pgCnt_q + 1'b1;
		end else begin
			if (regS) pgCnt_q <= DLY_ZERO;
			else if (pgCnt_q >= DLY_W'(DEGLITCH_CYCLES)) begin // RL11
				power_good <= 1'b0;
				pgCnt_q    <= DLY_ZERO;
			end else pgCnt_q <= pgCnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// oscillator tick divider
	// ----------------------------------------------------------------
	logic [OSC_DIV_W-1:0] divCnt_q;
	logic                 oscTick;
	assign oscTick = (divCnt_q == OSC_DIV_W'(OSC_DIV - 1));
	always_ff @(posedge core_clk) begin
		if (rst || oscTick) divCnt_q <= '0;
		else divCnt_q <= divCnt_q + 1'b1;
	end

	// ----------------------------------------------------------------
	// window lengths in oscillator ticks
	// ----------------------------------------------------------------
	logic [TICK_W-1:0] periodTicks, closedTicks, openTicks, initTicks, holdTicks;
	always_comb begin
		periodTicks = cfgS.periodRangeSelect ? ticksOf(BASE_TICKS * RANGE_MULT)
		                                     : ticksOf(BASE_TICKS); // RL2 RL3
		closedTicks = cfgS.windowRatioSelect ? periodTicks / ticksOf(RATIO_DIV) // RL6
		                                     : periodTicks >> 1; // RL5
		openTicks   = periodTicks - closedTicks; // RL7
		initTicks   = periodTicks * ticksOf(INIT_MULT); // RL4
		holdTicks   = periodTicks / ticksOf(HOLD_DIV); // RL18
	end

	// ----------------------------------------------------------------
	// watchdog state machine
	// ----------------------------------------------------------------
	wwdt_state_e       state_q;
	logic [TICK_W-1:0] tickCnt_q;
	logic              svcPrev_q, wdEnNPrev_q, pgPrev_q, isInit_q;
	logic              svcEvent, wdActive, reInit;

	assign svcEvent = svcS && !svcPrev_q; // RL20
	assign wdActive = power_good && !wdEnNS; // RL17
	assign reInit   = (power_good && !pgPrev_q) || (wdEnNPrev_q && !wdEnNS); // RL21

	always_ff @(posedge core_clk) begin
		if (rst) begin
			svcPrev_q   <= 1'b0;
			wdEnNPrev_q <= 1'b1;
			pgPrev_q    <= 1'b0;
		end else begin
			svcPrev_q   <= svcS;
			wdEnNPrev_q <= wdEnNS;
			pgPrev_q    <= power_good;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || !wdActive) begin // RL17
			state_q   <= WD_IDLE;
			tickCnt_q <= '0;
			isInit_q  <= 1'b0;
		end else if (reInit || state_q == WD_IDLE) begin
			state_q   <= WD_OPEN; // RL4 RL21
			tickCnt_q <= '0;
			isInit_q  <= 1'b1;
		end else begin
			unique case (state_q)
				WD_OPEN: begin
					if (svcEvent) begin // RL16
						tickCnt_q <= '0;
						isInit_q  <= 1'b0;
						state_q   <= cfgS.watchdogTypeSelect ? WD_OPEN : WD_CLOSED; // RL1 RL19
					end else if (oscTick) begin
						if (tickCnt_q + 1'b1 >= (isInit_q ? initTicks
						    : (cfgS.watchdogTypeSelect ? periodTicks : openTicks))) begin
							state_q   <= WD_FAULT; // RL8 RL9
							tickCnt_q <= '0;
						end else tickCnt_q <= tickCnt_q + 1'b1;
					end
				end
				WD_CLOSED: begin
					if (svcEvent) begin // RL9
						state_q   <= WD_FAULT;
						tickCnt_q <= '0;
					end else if (oscTick) begin
						if (tickCnt_q + 1'b1 >= closedTicks) begin
							state_q   <= WD_OPEN;
							tickCnt_q <= '0;
						end else tickCnt_q <= tickCnt_q + 1'b1;
					end
				end
				WD_FAULT: begin
					if (oscTick) begin
						if (tickCnt_q + 1'b1 >= holdTicks) begin // RL18
							state_q   <= WD_OPEN; // RL21
							tickCnt_q <= '0;
							isInit_q  <= 1'b1;
						end else tickCnt_q <= tickCnt_q + 1'b1;
					end
				end
				WD_IDLE: state_q <= WD_OPEN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// open-drain fault output and status
	// ----------------------------------------------------------------
	// registered, so pin lags the state by one cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fault_output_o    <= 1'b0;
			fault_output_oe_n <= 1'b1;
			watchdogRunning   <= 1'b0;
		end else begin
			fault_output_o    <= 1'b0;
			fault_output_oe_n <= !(wdActive && state_q == WD_FAULT); // RL17 RL18
			watchdogRunning   <= wdActive;
		end
	end
endmodule

/* dv/wwdt_mcu_model.sv */
`timescale 1ns/1ps
module wwdt_mcu_model #(
	parameter int PULSE_CYC = 8
) (
	input  wire logic core_clk,
	input  wire logic pulseReq,
	output logic      service_input
);
	// short pulse in sim, so it cannot straddle a narrow closed portion
	int hiLeft = 0;
	always @(posedge core_clk)
		hiLeft <= pulseReq ? PULSE_CYC : (hiLeft > 0 ? hiLeft - 1 : 0);
	// pulled low when idle; one rising edge per request
	assign service_input = hiLeft > 0;
endmodule

/* dv/wwdt_top_asserts.sv */
`timescale 1ns/1ps
module wwdt_top_asserts
	import wwdt_pkg::*;
#(
	parameter int DLY_FIX_CYCLES  = DLY_FIX_CYC,
	parameter int DEGLITCH_CYCLES = DEGLITCH_CYC
) (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        deviceEnable,
	input wire logic        underVoltage,
	input wire logic        thermalShutdown,
	input wire logic        outputInRegulation,
	input wire logic        delayCapFitted,
	input wire logic [23:0] delayCapCycles,
	input wire logic        watchdog_enable_n,
	input wire wwdt_cfg_s   cfgPins,
	input wire logic        regulatorOn,
	input wire logic        power_good,
	input wire logic        fault_output_oe_n,
	input wire logic        watchdogRunning
);
	logic [23:0] hiCnt, loCnt, oeCnt;
	int          hold;
	assign hold = BASE_TICKS * OSC_DIV / HOLD_DIV * (cfgPins.periodRangeSelect ? RANGE_MULT : 1);
	always_ff @(posedge core_clk) begin
		// any supply fault restarts the count, so a quick recovery cannot shortcut it
		hiCnt <= (rst || !outputInRegulation || underVoltage || thermalShutdown || !deviceEnable)
			? 24'h0 : hiCnt + 24'h1;
		loCnt <= (rst || outputInRegulation) ? 24'h0 : loCnt + 24'h1;
		oeCnt <= (rst || fault_output_oe_n) ? 24'h0 : oeCnt + 24'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence held4(s);
		s [*4];
	endsequence
	AST_OE_HIZ: assert property (!power_good [*2] |-> fault_output_oe_n && !watchdogRunning)
		else $error("fault pin or watchdog active without power good");
	AST_EN_OFF: assert property (held4(watchdog_enable_n) |=> !watchdogRunning)
		else $error("watchdog running while disabled");
	AST_REG_OFF: assert property (held4(!deviceEnable) |=> !regulatorOn && !power_good)
		else $error("regulator on while disabled");
	AST_UV_OFF: assert property (held4(underVoltage) |=> !power_good)
		else $error("power good kept in undervoltage");
	AST_TSD_OFF: assert property (held4(thermalShutdown) |=> !regulatorOn)
		else $error("regulator on in overtemperature");
	AST_PG_DELAY: assert property ($rose(power_good) |->
		hiCnt >= (delayCapFitted ? delayCapCycles : 24'(DLY_FIX_CYCLES)))
		else $error("power good rose before its delay");
	AST_PG_DEGLITCH: assert property ($fell(power_good) && deviceEnable && !underVoltage &&
		!thermalShutdown |-> loCnt >= 24'(DEGLITCH_CYCLES))
		else $error("power good fell before deglitch");
	AST_FAULT_HOLD: assert property ($rose(fault_output_oe_n) && power_good |->
		oeCnt >= hold - OSC_DIV && oeCnt <= hold + 1)
		else $error("fault pulse length wrong");
endmodule
bind wwdt_top wwdt_top_asserts #(.DLY_FIX_CYCLES(DLY_FIX_CYCLES),
	.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) u_chk (.*);

/* dv/window_watchdog_timer_bench.sv */
`timescale 1ns/1ps
module window_watchdog_timer_bench
	import wwdt_pkg::*;
;
	localparam int PER = BASE_TICKS * OSC_DIV;
	// fault pulse length in core cycles for the high range
	localparam int HOLD = RANGE_MULT * PER / HOLD_DIV;
	localparam logic [2:0] CFG [6] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h4, 3'h2};
	localparam int GAP [6] = '{1000, 2500, 600, 300, 100, 5000};
	localparam int EXP [6] = '{0, PER, PER, 0, PER, 0};
	localparam logic [2:0] BAD [3] = '{3'h0, 3'h6, 3'h5};
	logic        core_clk = 1'b0, underVoltage = 1'b0, thermalShutdown = 1'b0, pulseReq = 1'b0;
	logic        rst = 1'b1, deviceEnable = 1'b1, outputInRegulation = 1'b1;
	logic        watchdog_enable_n = 1'b1, delayCapFitted = 1'b0;
	logic [23:0] delayCapCycles = 24'h00001E;
	wwdt_cfg_s   cfgPins = 3'h0;
	logic        service_input, regulatorOn, power_good, fault_output_oe_n, watchdogRunning;
	logic        fault_output_o;
	int          err_count = 0, checked = 0, t;
	always #12.5 core_clk = ~core_clk;
	wwdt_top #(.DLY_FIX_CYCLES(20), .DEGLITCH_CYCLES(8)) u_dut (.*);
	wwdt_mcu_model u_mcu (.*);
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, s);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic waitOe(input logic lvl, input int lim);
		for (t = 0; fault_output_oe_n !== lvl; t++) begin
			if (t == lim) begin
				err_count++;
				$display("MISMATCH waitOe expected %0d seen %0d", lvl, fault_output_oe_n);
				test_done;
			end
			cyc(1);
		end
	endtask
	task automatic svc;
		pulseReq <= 1'b1;
		cyc(1);
		pulseReq <= 1'b0;
	endtask
	task automatic start(input logic [2:0] c);
		waitOe(1'b1, 4000);
		watchdog_enable_n <= 1'b1;
		cyc(5);
		cfgPins <= c;
		watchdog_enable_n <= 1'b0;
		cyc(5);
	endtask
	task automatic win(input int i);
		start(CFG[i]);
		svc();
		cyc(GAP[i]);
		svc();
		waitOe(1'b0, 20000);
		chk("faultAfter", 1'b1, t + 60 > EXP[i] && t < EXP[i] + 60);
		chk("faultLevel", 2'b00, {fault_output_o, fault_output_oe_n});
		$display("test window %0d done", i);
	endtask
	initial begin
		cyc(8);
		rst <= 1'b0;
		cyc(10);
		chk("pgEarly", 1'b0, power_good);
		cyc(30);
		chk("pgUp", 1'b1, power_good);
		outputInRegulation <= 1'b0;
		cyc(4);
		outputInRegulation <= 1'b1;
		cyc(10);
		chk("pgGlitch", 1'b1, power_good);
		outputInRegulation <= 1'b0;
		cyc(20);
		chk("pgDrop", 2'b01, {power_good, fault_output_oe_n});
		outputInRegulation <= 1'b1;
		delayCapFitted <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			{deviceEnable, underVoltage, thermalShutdown} <= BAD[i];
			cyc(10);
			chk("supplyOff", 2'b00, {regulatorOn, power_good});
			{deviceEnable, underVoltage, thermalShutdown} <= 3'h4;
			cyc(20);
			chk("pgRedelay", 1'b0, power_good);
			cyc(30);
			chk("pgBack", 1'b1, power_good);
		end
		$display("test powerSequence done");
		start(3'h0);
		chk("running", 1'b1, watchdogRunning);
		waitOe(1'b0, 30000);
		chk("initFault", 1'b1, t + 60 > 8 * PER && t < 8 * PER + 60);
		$display("test initWindow done");
		for (int i = 0; i < 6; i++)
			win(i);
		// last fault ends with the watchdog still enabled, so it must re-open
		waitOe(1'b1, 4000);
		chk("faultHold", 1'b1, t + 60 > HOLD && t < HOLD + 60);
		svc();
		cyc(100);
		chk("reInitOpen", 1'b1, fault_output_oe_n);
		$display("test faultEnd done");
		start(3'h0);
		test_done;
	end
endmodule
